// ### rtl/fcs_defs.svh
// register offsets, command bytes and timing counts of the flash command sequencer
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH
`define FCS_OFF_CTRL 8'h00
`define FCS_OFF_ADDR 8'h04
`define FCS_OFF_WDATA 8'h08
`define FCS_OFF_SMASK 8'h0c
`define FCS_OFF_STATUS 8'h10
`define FCS_CTRL_GO 3
`define FCS_ST_BUSY 0
`define FCS_ST_DONE 1
`define FCS_ST_ERR 2
`define FCS_ST_IDMODE 3
`define FCS_ST_RDATA 8
`define FCS_UNLOCK1_ADDR 17'h00555
`define FCS_UNLOCK2_ADDR 17'h002aa
`define FCS_UNLOCK1_DATA 8'haa
`define FCS_UNLOCK2_DATA 8'h55
`define FCS_CMD_IDENT 8'h90
`define FCS_CMD_PROG 8'ha0
`define FCS_CMD_ERASE 8'h80
`define FCS_CMD_CHIP 8'h10
`define FCS_CMD_SECT 8'h30
`define FCS_CMD_RESET 8'hf0
`define FCS_BIT_TOGGLE 6
`define FCS_BIT_TIMING 5
`define FCS_SECT_LSB 14
`define FCS_CLK_MHZ 100
`define FCS_T_WP_NS 30
`define FCS_T_ACC_NS 45
`define FCS_WP_CYC ((`FCS_T_WP_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_ACC_CYC ((`FCS_T_ACC_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_SE_WIN_US 50
`define FCS_SE_WIN_CYC (`FCS_SE_WIN_US * `FCS_CLK_MHZ)
`endif

// ### rtl/fcs_pkg.sv
// types shared by the flash command sequencer modules
`default_nettype none
package fcs_pkg;
  typedef enum logic [2:0] {
    OP_READ, OP_RESET, OP_IDENT, OP_PROG, OP_CHIP, OP_SECT
  } fcs_op_e;
  typedef enum logic [1:0] {S_IDLE, S_CMD, S_POLL} fcs_st_e;
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} fcs_cyc_e;
  typedef struct packed {
    logic wr;
    logic [16:0] addr;
    logic [7:0] data;
  } fcs_word_s;
endpackage
`default_nettype wire

// ### rtl/fcs_cyc_if.sv
// one flash bus cycle request and its answer between sequencer and pin engine
`default_nettype none
interface fcs_cyc_if;
  logic req;
  logic wr;
  logic [16:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctl (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ### rtl/fcs_bus_cycle.sv
// pin engine: runs one read or write strobe cycle on the flash pins
`include "fcs_defs.svh"
`default_nettype none
module fcs_bus_cycle
  import fcs_pkg::*;
#(
  parameter int WP_CYC = `FCS_WP_CYC,
  parameter int ACC_CYC = `FCS_ACC_CYC
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  fcs_cyc_if.eng cyc, // cycle request
  output logic [16:0] fl_addr, // flash address
  output logic fl_ce_n, // chip enable, low
  output logic fl_we_n, // write enable, low
  output logic fl_oe_n, // output enable, low
  input wire logic [7:0] fl_dq_in, // data pins in
  output logic [7:0] fl_dq_out, // data pins out
  output logic fl_dq_oe // data pins driven
);
  fcs_cyc_e st_q;
  logic wr_q;
  logic [7:0] cnt_q;
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;

  // two-flop synchroniser on the data pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= fl_dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // strobe sequencing: address first, then we or oe, data taken on the strobe's rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= C_IDLE;
      wr_q <= 1'b0;
      cnt_q <= 8'h00;
      fl_addr <= 17'h00000;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_dq_out <= 8'h00;
      fl_dq_oe <= 1'b0;
      cyc.done <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      unique case (st_q)
        C_IDLE: begin
          cyc.done <= 1'b0;
          if (cyc.req && !cyc.done) begin
            fl_addr <= cyc.addr; // address settles before the strobe falls
            fl_ce_n <= 1'b0;
            wr_q <= cyc.wr;
            fl_dq_out <= cyc.wdata;
            fl_dq_oe <= cyc.wr;
            st_q <= C_SETUP;
          end
        end
        C_SETUP: begin
          cnt_q <= 8'h00;
          if (wr_q) begin
            fl_we_n <= 1'b0;
          end else begin
            fl_oe_n <= 1'b0;
          end
          st_q <= C_STROBE;
        end
        C_STROBE: begin
          cnt_q <= cnt_q + 8'h01;
          if (wr_q && cnt_q == 8'(WP_CYC - 1)) begin
            fl_we_n <= 1'b1; // data held past this rise
            st_q <= C_HOLD;
          end else if (!wr_q && cnt_q == 8'(ACC_CYC + 1)) begin
            cyc.rdata <= dq_s2_q; // access time plus synchroniser delay
            fl_oe_n <= 1'b1;
            st_q <= C_HOLD;
          end
        end
        C_HOLD: begin
          fl_ce_n <= 1'b1;
          fl_dq_oe <= 1'b0;
          cyc.done <= 1'b1;
          st_q <= C_IDLE;
        end
      endcase
    end
  end

  a_we_with_ce: assert property (@(posedge pclk) disable iff (!presetn)
    !fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe) else $error("write strobe without ce or data");
  a_addr_held_we: assert property (@(posedge pclk) disable iff (!presetn)
    !fl_we_n && $past(!fl_we_n) |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("address or data moved during write strobe");
  a_we_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fl_we_n) |-> !fl_we_n [*3] ##1 fl_we_n) else $error("write strobe length wrong");
endmodule // fcs_bus_cycle
`default_nettype wire

// ### rtl/fcs_top.sv
// flash command sequencer: apb registers and the host-side command sequences
`include "fcs_defs.svh"
`default_nettype none
module fcs_top
  import fcs_pkg::*;
#(
  parameter int SE_WIN_CYC = `FCS_SE_WIN_CYC
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic [16:0] fl_addr, // flash address
  output logic fl_ce_n, // flash chip enable
  output logic fl_we_n, // flash write enable
  output logic fl_oe_n, // flash output enable
  input wire logic [7:0] fl_dq_in, // flash data in
  output logic [7:0] fl_dq_out, // flash data out
  output logic fl_dq_oe // flash data driven
);
  fcs_cyc_if cyc ();
  fcs_st_e st_q;
  fcs_op_e op_q;
  logic [2:0] step_q;
  logic [16:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] smask_q;
  logic [7:0] rdata_q;
  logic [7:0] prev_q;
  logic poll_second_q;
  logic retry_q;
  logic done_q;
  logic err_q;
  logic id_mode_q;
  logic [31:0] gap_q;
  logic acc;
  logic start;
  logic last;
  logic [2:0] sel;
  fcs_word_s cur;

  // lowest queued sector
  function automatic logic [2:0] first_set(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // the flash cycle of one step of a sequence
  function automatic fcs_word_s step_word(input fcs_op_e op, input logic [2:0] step,
      input logic [16:0] a, input logic [7:0] d, input logic [2:0] s);
    fcs_word_s w;
    w = '{wr: 1'b1, addr: `FCS_UNLOCK1_ADDR, data: `FCS_UNLOCK1_DATA};
    if (op == OP_READ) begin
      w = '{wr: 1'b0, addr: a, data: 8'h00};
    end else if (op == OP_RESET) begin
      w = '{wr: 1'b1, addr: a, data: `FCS_CMD_RESET};
    end else begin
      unique case (step)
        3'd1, 3'd4: w = '{wr: 1'b1, addr: `FCS_UNLOCK2_ADDR, data: `FCS_UNLOCK2_DATA};
        3'd2: begin
          w.data = (op == OP_IDENT) ? `FCS_CMD_IDENT :
                   (op == OP_PROG) ? `FCS_CMD_PROG : `FCS_CMD_ERASE;
        end
        3'd3: begin
          if (op == OP_PROG) begin
            w = '{wr: 1'b1, addr: a, data: d};
          end else if (op == OP_IDENT) begin
            w = '{wr: 1'b0, addr: a, data: 8'h00}; // id read at any address
          end
        end
        3'd5: begin
          if (op == OP_CHIP) begin
            w.data = `FCS_CMD_CHIP;
          end else begin
            w = '{wr: 1'b1, addr: {s, 14'h0000}, data: `FCS_CMD_SECT};
          end
        end
        default: w = w;
      endcase
    end
    return w;
  endfunction

  // current step and whether it ends the sequence
  always_comb begin
    sel = first_set(smask_q);
    cur = step_word(op_q, step_q, addr_q, wdata_q, sel);
    unique case (op_q)
      OP_READ, OP_RESET: last = 1'b1;
      OP_IDENT, OP_PROG: last = (step_q == 3'd3);
      OP_CHIP: last = (step_q == 3'd5);
      default: last = (step_q == 3'd5) && ((smask_q & ~(8'h01 << sel)) == 8'h00);
    endcase
  end

  assign acc = psel && penable && pready;
  assign start = acc && pwrite && paddr == `FCS_OFF_CTRL && pwdata[`FCS_CTRL_GO];

  // apb slave: one wait state, read data and error from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && penable && !pready) begin
        unique case (paddr)
          `FCS_OFF_CTRL: prdata <= {29'h0, op_q};
          `FCS_OFF_ADDR: prdata <= {15'h0, addr_q};
          `FCS_OFF_WDATA: prdata <= {24'h0, wdata_q};
          `FCS_OFF_SMASK: prdata <= {24'h0, smask_q};
          `FCS_OFF_STATUS: prdata <= {16'h0, rdata_q, 4'h0, id_mode_q, err_q, done_q,
                                      st_q != S_IDLE};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // operand registers, frozen while a sequence runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 17'h00000;
      wdata_q <= 8'h00;
    end else if (acc && pwrite && st_q == S_IDLE) begin
      if (paddr == `FCS_OFF_ADDR) begin
        addr_q <= pwdata[16:0];
      end
      if (paddr == `FCS_OFF_WDATA) begin
        wdata_q <= pwdata[7:0];
      end
    end
  end

  // cycles since the last unlock or sector cycle of a sector erase, to check the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 32'h00000000;
    end else if (cyc.done && op_q == OP_SECT && (step_q == 3'd4 || step_q == 3'd5)) begin
      gap_q <= 32'h00000000;
    end else if (gap_q != 32'hffffffff) begin
      gap_q <= gap_q + 32'h00000001;
    end
  end

  // sequencer: issues steps, then for program and erase polls the toggling status bit until it settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
      step_q <= 3'd0;
      smask_q <= 8'h00;
      rdata_q <= 8'h00;
      prev_q <= 8'h00;
      poll_second_q <= 1'b0;
      retry_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      id_mode_q <= 1'b0;
      cyc.req <= 1'b0;
      cyc.wr <= 1'b0;
      cyc.addr <= 17'h00000;
      cyc.wdata <= 8'h00;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (acc && pwrite && paddr == `FCS_OFF_SMASK) begin
            smask_q <= pwdata[7:0];
          end
          if (start) begin
            op_q <= fcs_op_e'(pwdata[2:0]);
            step_q <= 3'd0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            retry_q <= 1'b0;
            poll_second_q <= 1'b0;
            // no program or erase while identification mode holds
            if (pwdata[2:0] > 3'(OP_SECT) ||
                (id_mode_q && pwdata[2:0] >= 3'(OP_PROG)) ||
                (pwdata[2:0] == 3'(OP_SECT) && smask_q == 8'h00)) begin
              err_q <= 1'b1;
              done_q <= 1'b1;
            end else begin
              st_q <= S_CMD;
            end
          end
        end
        S_CMD: begin
          if (!cyc.req) begin
            cyc.req <= 1'b1;
            cyc.wr <= cur.wr;
            cyc.addr <= cur.addr;
            cyc.wdata <= cur.data;
          end else if (cyc.done) begin
            cyc.req <= 1'b0;
            if (!cyc.wr) begin
              rdata_q <= cyc.rdata;
            end
            if (op_q == OP_IDENT && step_q == 3'd2) begin
              id_mode_q <= 1'b1;
            end
            if (op_q == OP_RESET) begin
              id_mode_q <= 1'b0;
            end
            if (op_q == OP_SECT && step_q == 3'd5) begin
              smask_q <= smask_q & ~(8'h01 << sel); // next sector back to back
            end
            if (!last) begin
              step_q <= (op_q == OP_SECT && step_q == 3'd5) ? step_q : step_q + 3'd1;
            end else if (op_q >= OP_PROG) begin
              st_q <= S_POLL; // nothing else written until settled
            end else begin
              done_q <= 1'b1;
              st_q <= S_IDLE;
            end
          end
        end
        S_POLL: begin
          if (!cyc.req) begin
            cyc.req <= 1'b1;
            cyc.wr <= 1'b0;
            cyc.addr <= addr_q;
          end else if (cyc.done) begin
            cyc.req <= 1'b0;
            rdata_q <= cyc.rdata;
            prev_q <= cyc.rdata;
            poll_second_q <= !poll_second_q;
            if (poll_second_q) begin
              if (prev_q[`FCS_BIT_TOGGLE] == cyc.rdata[`FCS_BIT_TOGGLE]) begin
                done_q <= 1'b1;
                st_q <= S_IDLE;
              end else if (cyc.rdata[`FCS_BIT_TIMING]) begin
                if (retry_q) begin
                  err_q <= 1'b1; // timing exceeded: send reset to recover
                  op_q <= OP_RESET;
                  step_q <= 3'd0;
                  st_q <= S_CMD;
                end
                retry_q <= 1'b1;
              end
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  fcs_bus_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .cyc(cyc.eng),
    .fl_addr(fl_addr),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n),
    .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe)
  );

  a_unlock_first: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_CMD && $rose(cyc.req) && step_q == 3'd0 && op_q >= OP_IDENT
    |-> cyc.addr == 17'h00555 && cyc.wdata == 8'haa && cyc.wr)
    else $error("sequence did not open with first unlock");
  a_unlock_second: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cyc.req) && (step_q == 3'd1 || step_q == 3'd4) && st_q == S_CMD && op_q >= OP_IDENT
    |-> cyc.addr == 17'h002aa && cyc.wdata == 8'h55) else $error("second unlock wrong");
  a_prog_word: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cyc.req) && st_q == S_CMD && op_q == OP_PROG && step_q == 3'd3
    |-> cyc.wr && cyc.addr == addr_q && cyc.wdata == wdata_q)
    else $error("program cycle not at target");
  a_chip_final: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cyc.req) && st_q == S_CMD && op_q == OP_CHIP && step_q == 3'd5
    |-> cyc.wdata == 8'h10 && cyc.addr == 17'h00555) else $error("chip erase command wrong");
  a_sect_final: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cyc.req) && st_q == S_CMD && op_q == OP_SECT && step_q == 3'd5
    |-> cyc.wdata == 8'h30 && smask_q[cyc.addr[16:14]]) else $error("sector cycle wrong");
  a_sect_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_CMD && op_q == OP_SECT && step_q == 3'd5 && $rose(cyc.req)
    |-> gap_q < SE_WIN_CYC) else $error("sector cycles too far apart");
  a_id_exit_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(id_mode_q) |-> $past(op_q) == OP_RESET && $past(cyc.done))
    else $error("identification mode left without reset");
  a_ident_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(id_mode_q) |-> $past(cyc.wdata) == 8'h90 && $past(cyc.addr) == 17'h00555)
    else $error("identification mode without its command");
  a_poll_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_POLL && cyc.req |-> !cyc.wr) else $error("write issued while device busy");
endmodule // fcs_top
`default_nettype wire

// ### tb/fcs_flash_model.sv
// behavioural byte-wide flash device answering the sequencer's pins
`default_nettype none
module fcs_flash_model #(
  parameter logic [7:0] MAKER = 8'h5c, // arbitrary maker code
  parameter logic [7:0] PART = 8'hc3, // arbitrary part code
  parameter logic [7:0] PROT = 8'h24, // protected sector map
  parameter int BUSY_NS = 3000, // embedded algorithm length
  parameter int WIN_NS = 50000 // sector erase collection time-out
) (
  input wire logic [16:0] fl_addr, // address pins
  input wire logic fl_ce_n, // chip enable, low
  input wire logic fl_we_n, // write enable, low
  input wire logic fl_oe_n, // output enable, low
  input wire logic [7:0] fl_dq_out, // data from the sequencer
  output logic [7:0] fl_dq_in // data to the sequencer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:131071]; // array contents
  logic [7:0] rd = 8'hff; // last byte put on the pins
  logic [16:0] la; // latched write address
  logic wa = 1'b0; // write cycle open
  logic tog = 1'b0; // toggling status bit
  logic gone = 1'b0; // queued sectors already erased
  logic fail = 1'b0; // program tried to raise a zero bit
  logic [7:0] pdat = 8'h00; // byte under programming
  logic [7:0] sq = 8'h00; // sectors queued for erase
  int st = 0; // position in the unlock sequence
  int mode = 0; // 0 array, 1 ident, 2 program, 3 chip erase, 4 sector erase
  int nwr = 0; // write strobes seen
  time bend = 0; // end of the embedded algorithm
  time wend = 0; // end of the collection window
  // erased array at power-up
  initial foreach (mem[i]) mem[i] = 8'hff;
  // retire a finished algorithm, erasing queued sectors when the window closes
  function automatic void settle();
    if (mode == 4 && $time >= wend && !gone) begin
      gone = 1'b1;
      foreach (mem[i]) if (sq[i[16:14]]) mem[i] = 8'hff;
    end
    if (mode > 1 && $time >= bend && !fail) mode = 0;
  endfunction
  // command decoder; a busy device drops writes, save writes in the sector erase window and a reset after a failed program
  function automatic void cmd(input logic [16:0] a, input logic [7:0] d);
    settle();
    nwr++;
    if (mode == 4 && $time < wend) begin
      if (d == 8'h30) begin
        sq[a[16:14]] = 1'b1;
        wend = $time + WIN_NS;
        bend = wend + BUSY_NS;
      end else mode = 0;
    end else if (mode < 2 || (fail && d == 8'hf0)) begin
      if (d == 8'hf0) begin
        mode = 0;
        st = 0;
        fail = 1'b0;
      end else if (mode == 0) begin
        case (st)
          0: st = (a[10:0] == 11'h555 && d == 8'haa) ? 1 : 0;
          1: st = (a[10:0] == 11'h2aa && d == 8'h55) ? 2 : 0;
          2: begin
            st = 0;
            if (a[10:0] == 11'h555 && d == 8'h90) mode = 1;
            if (a[10:0] == 11'h555 && d == 8'ha0) st = 3;
            if (a[10:0] == 11'h555 && d == 8'h80) st = 4;
          end
          3: begin
            st = 0;
            pdat = d;
            if (|(d & ~mem[a])) fail = 1'b1;
            mem[a] = mem[a] & d;
            mode = 2;
            bend = $time + BUSY_NS;
          end
          4: st = (a[10:0] == 11'h555 && d == 8'haa) ? 5 : 0;
          5: st = (a[10:0] == 11'h2aa && d == 8'h55) ? 6 : 0;
          default: begin
            st = 0;
            if (a[10:0] == 11'h555 && d == 8'h10) begin
              foreach (mem[i]) mem[i] = 8'hff;
              mode = 3;
              bend = $time + BUSY_NS;
            end else if (d == 8'h30) begin
              mode = 4;
              gone = 1'b0;
              sq = 8'h00;
              sq[a[16:14]] = 1'b1;
              wend = $time + WIN_NS;
              bend = wend + BUSY_NS;
            end
          end
        endcase
      end
    end
  endfunction
  // read cycle: id codes, status while busy, else array
  always @(negedge fl_oe_n) if (!fl_ce_n) begin
    settle();
    if (mode == 1) begin
      rd = 8'h00;
      if (fl_addr[7:0] == 8'h00) rd = MAKER;
      if (fl_addr[7:0] == 8'h01) rd = PART;
      if (fl_addr[7:0] == 8'h02) rd = {7'h00, PROT[fl_addr[16:14]]};
    end else if (mode > 1) begin
      tog = ~tog;
      rd = {mode == 2 ? ~pdat[7] : 1'b0, tog, fail, 1'b0, mode == 4 && $time >= wend, 3'b000};
    end else rd = mem[fl_addr];
  end
  // address on the later falling strobe, data on the earlier rising one
  always @(negedge fl_we_n or negedge fl_ce_n)
    if (!fl_we_n && !fl_ce_n && fl_oe_n) begin
      la = fl_addr;
      wa = 1'b1;
    end
  always @(posedge fl_we_n or posedge fl_ce_n)
    if (wa) begin
      wa = 1'b0;
      cmd(la, fl_dq_out);
    end
  // a released bus shows the inverse of the last byte
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~rd;
endmodule // fcs_flash_model
`default_nettype wire

// ### tb/tb_fcs_top.sv
// self-checking bench: apb scenarios against the sequencer and flash model
`include "fcs_defs.svh"
`default_nettype none
module tb_fcs_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h5c; // arbitrary maker code
  localparam logic [7:0] PART = 8'hc3; // arbitrary part code
  localparam logic [7:0] PROT = 8'h24; // protected sector map
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [16:0] fl_addr;
  logic fl_ce_n;
  logic fl_we_n;
  logic fl_oe_n;
  logic [7:0] fl_dq_in;
  logic [7:0] fl_dq_out;
  logic fl_dq_oe;
  logic [31:0] dr; // discarded read data
  logic de; // discarded error flag
  logic [31:0] s; // last status word
  int nw; // flash writes of the last operation
  int err_total = 0;
  int checks = 0;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  fcs_top fcs_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fl_addr, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_dq_in,
    .fl_dq_out, .fl_dq_oe);
  fcs_flash_model #(.MAKER(MAKER), .PART(PART), .PROT(PROT)) fcs_flash_model_inst (
    .fl_addr, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_dq_out, .fl_dq_in);
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // set up and start one operation, then poll status until done
  task automatic run(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d,
                     input logic [7:0] m, input logic bump);
    int w0;
    int n;
    apb(1'b1, `FCS_OFF_ADDR, {15'h0, a}, dr, de);
    apb(1'b1, `FCS_OFF_WDATA, {24'h0, d}, dr, de);
    apb(1'b1, `FCS_OFF_SMASK, {24'h0, m}, dr, de);
    w0 = fcs_flash_model_inst.nwr;
    apb(1'b1, `FCS_OFF_CTRL, {28'h0, 1'b1, op}, dr, de);
    if (bump) apb(1'b1, `FCS_OFF_CTRL, 32'h0000000b, dr, de);
    n = 0;
    do begin
      apb(1'b0, `FCS_OFF_STATUS, 32'h0, s, de);
      n++;
    end while (s[`FCS_ST_DONE] !== 1'b1 && n < 4000);
    if (s[`FCS_ST_DONE] !== 1'b1) begin
      err_total++;
      conclude();
    end
    nw = fcs_flash_model_inst.nwr - w0;
  endtask
  task automatic peek(input logic [16:0] a, input logic [7:0] x);
    run(3'd0, a, 8'h00, 8'h00, 1'b0);
    chk(s[15:8], x);
  endtask
  // idle after reset, unmapped address refused
  task automatic t_reset();
    apb(1'b0, `FCS_OFF_STATUS, 32'h0, dr, de);
    chk(dr, 32'h0);
    chk({28'h0, fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe}, 32'he);
    apb(1'b0, 8'h14, 32'h0, dr, de);
    chk({dr[30:0], de}, 32'h1);
  endtask
  // identification codes, protection query per sector, exit by reset
  task automatic t_ident();
    run(3'd2, 17'h00000, 8'h00, 8'h00, 1'b0);
    chk({s[15:8], s[3:0], 4'(nw)}, {MAKER, 4'ha, 4'h3});
    run(3'd0, 17'h1ff01, 8'h00, 8'h00, 1'b0);
    chk({s[15:8], s[3:0]}, {PART, 4'ha});
    for (int i = 0; i < 8; i++) begin
      peek({i[2:0], 14'h0002}, {7'h00, PROT[i]});
    end
    run(3'd3, 17'h00100, 8'h00, 8'h00, 1'b0);
    chk({s[3:0], 4'(nw)}, 8'he0);
    run(3'd1, 17'h1abcd, 8'h00, 8'h00, 1'b0);
    chk({s[3:0], 4'(nw)}, 8'h21);
    peek(17'h00001, 8'hff);
  endtask
  // program, clearing only, crossing sectors
  task automatic t_prog();
    run(3'd3, 17'h04000, 8'h5a, 8'h00, 1'b0);
    chk({s[15:8], s[3:0], 4'(nw)}, {8'h5a, 4'h2, 4'h4});
    run(3'd3, 17'h04000, 8'ha5, 8'h00, 1'b0);
    chk({s[3:0], 4'(nw)}, 8'h65);
    peek(17'h04000, 8'h00);
    run(3'd3, 17'h13fff, 8'h12, 8'h00, 1'b0);
    run(3'd3, 17'h14000, 8'h34, 8'h00, 1'b0);
    peek(17'h13fff, 8'h12);
    peek(17'h14000, 8'h34);
  endtask
  // chip erase with a go pushed while busy
  task automatic t_chip();
    run(3'd4, 17'h04000, 8'h00, 8'h00, 1'b1);
    chk({s[15:8], s[3:0], 4'(nw)}, {8'hff, 4'h2, 4'h6});
    peek(17'h14000, 8'hff);
  endtask
  // two sectors queued in one window, a neighbour kept, empty queue and bad op refused
  task automatic t_sect();
    run(3'd3, 17'h08000, 8'h11, 8'h00, 1'b0);
    run(3'd3, 17'h0c000, 8'h22, 8'h00, 1'b0);
    run(3'd3, 17'h18000, 8'h33, 8'h00, 1'b0);
    run(3'd5, 17'h08000, 8'h00, 8'h44, 1'b0);
    chk({s[3:0], 4'(nw), fcs_flash_model_inst.sq}, {4'h2, 4'h7, 8'h44});
    peek(17'h18000, 8'hff);
    peek(17'h08000, 8'hff);
    peek(17'h0c000, 8'h22);
    run(3'd5, 17'h00000, 8'h00, 8'h00, 1'b0);
    chk({s[3:0], 4'(nw)}, 8'h60);
    run(3'd6, 17'h00000, 8'h00, 8'h00, 1'b0);
    chk({s[3:0], 4'(nw)}, 8'h60);
  endtask
  // reset for two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ident();
    t_prog();
    t_chip();
    t_sect();
    conclude();
  end
endmodule // tb_fcs_top
`default_nettype wire
